// ### coil_current_protection_front_end.v
`timescale 1ns/1ps
`default_nettype none
`include "coil_protect_defs.vh"
// Functional notes
// (RL1) latch inputs at each step start, publish results at that step's end
// (RL2) pulse/standby state follows synchronised start/end events plus delays
// (RL3) enter pulse delay_x steps after start, standby delay_y after end; code switches delay_x+1, delay_y+1 steps after taking the event
// (RL4) maximum pulse and minimum standby durations are writable registers
// (RL5) fault on too-long pulse or too-short standby
// (RL6) four signals per coil processed every step in every state
// (RL7) coil offsets are 100-sample moving averages of standby samples
// (RL8) offsets update in standby only, subtract in pulse only
// (RL9) fault when any coil offset exceeds its limit
// (RL10) first check compares each direct reading with its conditioned copy
// (RL11) first check uses raw values in standby, corrected values in pulse
// (RL12) separate discrepancy limits per state and per comparison stage
// (RL13) larger magnitude picked after each stage; final pick is coil current
// (RL14) optional filtering of direct readings before comparison
// (RL15) two plasma signals compared, larger magnitude is plasma current
// (RL16) plasma offsets averaged over 100 standby samples, subtracted in pulse
// (RL17) plasma signals corrected for solenoid and field coil pick-up
// (RL18) fault on plasma offset over limit or signals disagreeing, any state
// (RL19) fault in standby when selected plasma current exceeds limit
// (RL20) prediction enabled only in pulse state
// (RL21) faults stay set until cleared by a control write
module coil_current_protection_front_end (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire start_of_pulse_event,
  input wire end_of_pulse_event,
  input wire [`NUM_COILS*2*`SAMPLE_W-1:0] current_transducer,
  input wire [`NUM_COILS*2*`SAMPLE_W-1:0] conditioned_signal_copy,
  input wire [2*`SAMPLE_W-1:0] plasma_current,
  output reg [`NUM_COILS*`SAMPLE_W-1:0] coil_current,
  output reg [`SAMPLE_W-1:0] plasma_current_sel,
  output reg pulse_state,
  output reg predict_enable,
  output reg step_done,
  output reg fault,
  output reg [`NUM_FAULTS-1:0] fault_status
);
  localparam NC = `NUM_COILS;
  localparam NCH = NC * 4 + 2;
  localparam W = `SAMPLE_W;
  localparam ST_STBY = 2'h0;
  localparam ST_WAIT_P = 2'h1;
  localparam ST_PULSE = 2'h2;
  localparam ST_WAIT_S = 2'h3;

  function [W:0] mag;
    input [W:0] v;
    begin
      mag = v[W] ? (~v + 1'b1) : v;
    end
  endfunction

  // true when two corrected values differ by more than the limit
  function over_diff;
    input [W:0] a;
    input [W:0] b;
    input [W-1:0] lim;
    reg [W+1:0] d;
    begin
      d = {a[W], a} - {b[W], b};
      over_diff = (d[W+1] ? (~d + 1'b1) : d) > {2'b00, lim};
    end
  endfunction

  // step divider
  reg [`STEP_CNT_W-1:0] div_q;
  reg tick_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= {`STEP_CNT_W{1'b0}};
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == `STEP_CYCLES - 1);
      div_q <= (div_q == `STEP_CYCLES - 1) ? {`STEP_CNT_W{1'b0}} : div_q + 1'b1;
    end
  end

  // timing events cross in through three flops, held pending until the next step
  reg [2:0] sop_s_q, eop_s_q;
  reg sop_pend_q, eop_pend_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      sop_s_q <= 3'h0;
      eop_s_q <= 3'h0;
      sop_pend_q <= 1'b0;
      eop_pend_q <= 1'b0;
    end else begin
      sop_s_q <= {sop_s_q[1:0], start_of_pulse_event};
      eop_s_q <= {eop_s_q[1:0], end_of_pulse_event};
      sop_pend_q <= (sop_pend_q & ~tick_q) | (sop_s_q[1] & ~sop_s_q[2]); // [RL2]
      eop_pend_q <= (eop_pend_q & ~tick_q) | (eop_s_q[1] & ~eop_s_q[2]); // [RL2]
    end
  end

  // configuration registers, indexed by word address
  reg [W-1:0] cfg_q [2:15];
  reg [1:0] ctrl_q;
  reg [NCH*W-1:0] smp_q;
  reg [NC*2*W-1:0] flt_q;
  reg [1:0] st_q;
  reg [W-1:0] wait_q, plen_q, slen_q;
  wire in_pulse = st_q[1];
  wire [W-1:0] delay_x = cfg_q[`REG_DELAY_X >> 2];
  wire [W-1:0] delay_y = cfg_q[`REG_DELAY_Y >> 2];
  wire [W-1:0] max_pulse = cfg_q[`REG_MAX_PULSE >> 2]; // [RL4]
  wire [W-1:0] min_stby = cfg_q[`REG_MIN_STANDBY >> 2]; // [RL4]
  wire [W-1:0] lim1 = in_pulse ? cfg_q[`REG_DISC1_PULSE >> 2] : cfg_q[`REG_DISC1_STBY >> 2]; // [RL12]
  wire [W-1:0] lim2 = in_pulse ? cfg_q[`REG_DISC2_PULSE >> 2] : cfg_q[`REG_DISC2_STBY >> 2]; // [RL12]

  // state machine, advanced once per step; wait states count as the old state
  reg st_fault_long, st_fault_short;
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_STBY;
      wait_q <= `RST_ZERO;
      plen_q <= `RST_ZERO;
      slen_q <= `RST_ZERO;
      st_fault_long <= 1'b0;
      st_fault_short <= 1'b0;
    end else begin
      st_fault_long <= 1'b0;
      st_fault_short <= 1'b0;
      if (tick_q) begin
        wait_q <= wait_q + 1'b1;
        case (st_q)
          ST_STBY: begin
            if (slen_q != 16'hFFFF) slen_q <= slen_q + 1'b1;
            if (sop_pend_q) begin
              st_q <= ST_WAIT_P;
              wait_q <= `RST_ZERO;
            end
          end
          ST_WAIT_P: begin
            if (slen_q != 16'hFFFF) slen_q <= slen_q + 1'b1;
            if (wait_q >= delay_x) begin // [RL3]
              st_q <= ST_PULSE;
              plen_q <= `RST_ZERO;
              st_fault_short <= (slen_q < min_stby); // [RL5]
            end
          end
          ST_PULSE, ST_WAIT_S: begin
            if (plen_q != 16'hFFFF) plen_q <= plen_q + 1'b1;
            st_fault_long <= (plen_q >= max_pulse); // [RL5]
            if (st_q == ST_PULSE && eop_pend_q) begin
              st_q <= ST_WAIT_S;
              wait_q <= `RST_ZERO;
            end else if (st_q == ST_WAIT_S && wait_q >= delay_y) begin // [RL3]
              st_q <= ST_STBY;
              slen_q <= `RST_ZERO;
            end
          end
          default: st_q <= ST_STBY;
        endcase
      end
    end
  end

  // sample latch at step start; first-order smoothing of direct readings
  reg [`AVG_IDX_W-1:0] avg_idx_q;
  reg avg_full_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      smp_q <= {NCH*W{1'b0}};
      avg_idx_q <= {`AVG_IDX_W{1'b0}};
      avg_full_q <= 1'b0;
    end else if (tick_q) begin
      smp_q <= {plasma_current, conditioned_signal_copy, current_transducer}; // [RL1] [RL6]
      if (!in_pulse) begin
        avg_idx_q <= (avg_idx_q == `AVG_DEPTH - 1) ? {`AVG_IDX_W{1'b0}} : avg_idx_q + 1'b1;
        if (avg_idx_q == `AVG_DEPTH - 1) avg_full_q <= 1'b1;
      end
    end
  end

  // channel order: directs, conditioned copies, plasma a/b
  wire [NCH*(W+1)-1:0] cv;
  wire [NCH-1:0] ofs_bad;
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : chan
      reg [W-1:0] ring [0:`AVG_DEPTH-1];
      reg signed [W+`AVG_IDX_W-1:0] sum_q;
      reg signed [W-1:0] ofs_q;
      wire signed [W-1:0] raw = smp_q[g*W +: W];
      wire signed [W-1:0] src;
      wire signed [W-1:0] oldest = avg_full_q ? ring[avg_idx_q] : `RST_ZERO;
      wire signed [W+`AVG_IDX_W-1:0] sum_n = sum_q + raw - oldest;
      wire signed [W+`AVG_IDX_W-1:0] avg = sum_n / `AVG_DEPTH;
      always @(posedge aclk) begin
        if (tick_q && !in_pulse) ring[avg_idx_q] <= raw; // [RL7] [RL16]
      end
      always @(posedge aclk) begin
        if (!aresetn) begin
          sum_q <= {W+`AVG_IDX_W{1'b0}};
          ofs_q <= `RST_ZERO;
        end else if (tick_q && !in_pulse) begin // [RL8]
          sum_q <= sum_n;
          ofs_q <= avg[W-1:0];
        end
      end
      if (g < NC * 2) begin : dfilt
        reg signed [W-1:0] f_q;
        wire signed [W:0] step = $signed({raw[W-1], raw} - {f_q[W-1], f_q}) >>> `FILT_SHIFT;
        always @(posedge aclk) begin
          if (!aresetn) f_q <= `RST_ZERO;
          else if (tick_q) f_q <= f_q + step[W-1:0]; // [RL14]
        end
        assign src = ctrl_q[`CTRL_FILT_EN] ? f_q : raw; // [RL14]
      end else begin : nofilt
        assign src = raw;
      end
      assign cv[g*(W+1) +: W+1] = in_pulse ? {src[W-1], src} - {ofs_q[W-1], ofs_q} : {src[W-1], src}; // [RL8] [RL11]
      wire [W-1:0] lim = (g >= NC * 4) ? cfg_q[`REG_PLS_OFS_LIM >> 2] : cfg_q[`REG_COIL_OFS_LIM >> 2];
      assign ofs_bad[g] = mag({ofs_q[W-1], ofs_q}) > {1'b0, lim}; // [RL9] [RL18]
    end
  endgenerate

  // two-stage cross-check and auction per coil
  wire [NC-1:0] d1_bad, d2_bad;
  wire [NC*(W+1)-1:0] sel;
  generate
    for (g = 0; g < NC; g = g + 1) begin : coil
      wire [W:0] da = cv[(2*g)*(W+1) +: W+1];
      wire [W:0] db = cv[(2*g+1)*(W+1) +: W+1];
      wire [W:0] ka = cv[(NC*2+2*g)*(W+1) +: W+1];
      wire [W:0] kb = cv[(NC*2+2*g+1)*(W+1) +: W+1];
      wire [W:0] ta = (mag(da) >= mag(ka)) ? da : ka; // [RL13]
      wire [W:0] tb = (mag(db) >= mag(kb)) ? db : kb; // [RL13]
      assign d1_bad[g] = over_diff(da, ka, lim1) | over_diff(db, kb, lim1); // [RL10]
      assign d2_bad[g] = over_diff(ta, tb, lim2);
      assign sel[g*(W+1) +: W+1] = (mag(ta) >= mag(tb)) ? ta : tb; // [RL13]
    end
  endgenerate

  // plasma pick-up correction uses last step's coil currents; coil 0 is the solenoid
  wire signed [W-1:0] coef_cs = cfg_q[`REG_COEF_CS >> 2];
  wire signed [W-1:0] coef_pf = cfg_q[`REG_COEF_PF >> 2];
  wire signed [W-1:0] i_cs = coil_current[W-1:0];
  wire signed [W-1:0] i_pf = coil_current[2*W-1:W];
  wire signed [2*W+1:0] pickup = (coef_cs * i_cs + coef_pf * i_pf) >>> `COEF_FRAC;
  wire signed [W:0] pa = cv[(NC*4)*(W+1) +: W+1];
  wire signed [W:0] pb = cv[(NC*4+1)*(W+1) +: W+1];
  wire [W:0] pac = pa - pickup[W:0]; // [RL17]
  wire [W:0] pbc = pb - pickup[W:0]; // [RL17]
  wire [W:0] psel = (mag(pac) >= mag(pbc)) ? pac : pbc; // [RL15]

  wire [`NUM_FAULTS-1:0] fault_new;
  assign fault_new[`FLT_PULSE_LONG] = st_fault_long;
  assign fault_new[`FLT_STBY_SHORT] = st_fault_short;
  assign fault_new[`FLT_COIL_OFS] = tick_q & (|ofs_bad[NC*4-1:0]);
  assign fault_new[`FLT_DISC1] = tick_q & (|d1_bad);
  assign fault_new[`FLT_DISC2] = tick_q & (|d2_bad);
  assign fault_new[`FLT_PLS_OFS] = tick_q & (|ofs_bad[NCH-1:NC*4]); // [RL18]
  assign fault_new[`FLT_PLS_DISC] = tick_q & over_diff(pac, pbc, cfg_q[`REG_PLS_DISC_LIM >> 2]); // [RL15] [RL18]
  assign fault_new[`FLT_PLS_STBY] = tick_q & ~in_pulse &
    (mag(psel) > {1'b0, cfg_q[`REG_PLS_STBY_LIM >> 2]}); // [RL19]

  // results published at the end of the step, as the next step begins
  integer i;
  always @(posedge aclk) begin
    if (!aresetn) begin
      coil_current <= {NC*W{1'b0}};
      plasma_current_sel <= `RST_ZERO;
      pulse_state <= 1'b0;
      predict_enable <= 1'b0;
      step_done <= 1'b0;
      fault_status <= {`NUM_FAULTS{1'b0}};
      fault <= 1'b0;
    end else begin
      step_done <= tick_q; // [RL1]
      if (tick_q) begin
        for (i = 0; i < NC; i = i + 1)
          coil_current[i*W +: W] <= sel[i*(W+1) +: W]; // [RL1]
        plasma_current_sel <= psel[W-1:0];
        pulse_state <= in_pulse;
        predict_enable <= in_pulse; // [RL20]
      end
      // a new fault wins over a clear in the same cycle
      fault_status <= (fault_status & ~{`NUM_FAULTS{ctrl_q[`CTRL_FAULT_CLR]}}) | fault_new; // [RL21]
      fault <= |((fault_status & ~{`NUM_FAULTS{ctrl_q[`CTRL_FAULT_CLR]}}) | fault_new); // [RL21]
    end
  end
  integer j;
  // bus slave: write taken when address and data are both present
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
  wire [5:0] wa = s_axi_awaddr[7:2];
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      ctrl_q <= 2'h0;
      for (j = 2; j < 16; j = j + 1) cfg_q[j] <= `RST_LIMIT;
      cfg_q[`REG_DELAY_X >> 2] <= `RST_ZERO;
      cfg_q[`REG_DELAY_Y >> 2] <= `RST_ZERO;
      cfg_q[`REG_MAX_PULSE >> 2] <= `RST_MAX_PULSE;
      cfg_q[`REG_MIN_STANDBY >> 2] <= `RST_ZERO;
      cfg_q[`REG_COEF_CS >> 2] <= `RST_ZERO;
      cfg_q[`REG_COEF_PF >> 2] <= `RST_ZERO;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      ctrl_q[`CTRL_FAULT_CLR] <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      if (s_axi_awready) s_axi_bvalid <= 1'b1;
      if (wr_go) begin
        s_axi_bresp <= (s_axi_awaddr[31:6] == 26'h0 && wa != (`REG_STATUS >> 2)) ? `RESP_OKAY : `RESP_SLVERR;
        if (s_axi_awaddr[31:6] == 26'h0) begin
          if (wa == (`REG_CTRL >> 2) && s_axi_wstrb[0])
            ctrl_q <= s_axi_wdata[1:0]; // [RL21]
          else if (wa >= 6'h2) begin
            if (s_axi_wstrb[0]) cfg_q[wa[3:0]][7:0] <= s_axi_wdata[7:0];
            if (s_axi_wstrb[1]) cfg_q[wa[3:0]][15:8] <= s_axi_wdata[15:8];
          end
        end
      end
    end
  end

  wire [5:0] ra = s_axi_araddr[7:2];
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
      if (s_axi_arready) s_axi_rvalid <= 1'b1;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        s_axi_rdata <= 32'h00000000;
        if (s_axi_araddr[31:7] != 25'h0) s_axi_rresp <= `RESP_SLVERR;
        else if (ra == (`REG_CTRL >> 2)) s_axi_rdata <= {30'h0, ctrl_q[`CTRL_FILT_EN], 1'b0};
        else if (ra == (`REG_STATUS >> 2)) s_axi_rdata <= {16'h0, fault_status, 6'h0, st_q};
        else if (ra < 6'h10) s_axi_rdata <= {16'h0, cfg_q[ra[3:0]]};
        else if (ra == (`REG_COIL_BASE >> 2)) s_axi_rdata <= {16'h0, coil_current[W-1:0]};
        else if (ra == (`REG_COIL_BASE >> 2) + 1) s_axi_rdata <= {16'h0, coil_current[2*W-1:W]};
        else if (ra == (`REG_PLASMA >> 2)) s_axi_rdata <= {16'h0, plasma_current_sel};
        else s_axi_rresp <= `RESP_SLVERR;
      end
    end
  end
endmodule // coil_current_protection_front_end
`default_nettype wire

// ### coil_current_protection_front_end_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "coil_protect_defs.vh"
module coil_current_protection_front_end_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] aw_addr = 32'h0, w_data = 32'h0, ar_addr = 32'h0, r_data, pl = 32'h0, coil_current, plasma;
  logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid, sop, eop, pulse_state, predict_enable, step_done, fault;
  logic [1:0] b_resp, r_resp;
  logic sop_req = 1'b0, eop_req = 1'b0;
  logic [15:0] c0 = 16'h0000, c1 = 16'h0000, skew = 16'h0000, plasma_sel;
  logic [63:0] direct, cond;
  logic [7:0] fault_status;
  int mismatches = 0, comparisons = 0;
  coil_current_protection_front_end DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready), .s_axi_wdata(w_data),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(w_valid), .s_axi_wready(w_ready), .s_axi_bresp(b_resp),
    .s_axi_bvalid(b_valid), .s_axi_bready(b_ready), .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid),
    .s_axi_arready(ar_ready), .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid),
    .s_axi_rready(r_ready), .start_of_pulse_event(sop), .end_of_pulse_event(eop),
    .current_transducer(direct), .conditioned_signal_copy(cond), .plasma_current(plasma),
    .coil_current(coil_current), .plasma_current_sel(plasma_sel), .pulse_state(pulse_state),
    .predict_enable(predict_enable), .step_done(step_done), .fault(fault), .fault_status(fault_status));
  sensor_front far (.aclk(aclk), .sop_req(sop_req), .eop_req(eop_req), .c0(c0), .c1(c1), .skew(skew),
    .pl(pl), .sop(sop), .eop(eop), .direct(direct), .cond(cond), .plasma(plasma));
  initial forever #25 aclk = ~aclk;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    aw_addr <= {24'h0, a};
    w_data <= d;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    // address and data are each released at the edge that takes them
    do begin
      @(posedge aclk);
      if (aw_ready === 1'b1) aw_valid <= 1'b0;
      if (w_ready === 1'b1) w_valid <= 1'b0;
    end while (b_valid !== 1'b1);
    chk("write response", {30'h0, er}, {30'h0, b_resp});
    b_ready <= 1'b0;
    // a spare cycle after the response; the slave can take the next write as soon as b_valid is low
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    ar_addr <= {24'h0, a};
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    do begin
      @(posedge aclk);
      if (ar_ready === 1'b1) ar_valid <= 1'b0;
    end while (r_valid !== 1'b1);
    chk("read data", ed, r_data);
    chk("read response", {30'h0, er}, {30'h0, r_resp});
    r_ready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic steps(input int k);
    int n;
    repeat (k) begin
      n = 0;
      do @(posedge aclk); while (step_done !== 1'b1 && ++n < 300);
      chk("step strobe", 32'h1, {31'h0, step_done});
    end
  endtask
  task automatic trig(input logic start);
    if (start) sop_req <= 1'b1;
    else eop_req <= 1'b1;
    @(posedge aclk);
    sop_req <= 1'b0;
    eop_req <= 1'b0;
  endtask
  task automatic end_sim;
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #4000000;
    mismatches++;
    end_sim;
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 16; i++)
      rd(8'(i * 4), (i == 4) ? 32'hFFFF : (i > 5 && i < 14) ? 32'h7FFF : 32'h0, `RESP_OKAY);
    rd(8'h80, 32'h0, `RESP_SLVERR);
    wr(`REG_STATUS, 32'h1, `RESP_SLVERR);
    wr(`REG_COIL_BASE, 32'h1, `RESP_SLVERR);
    wr(`REG_DELAY_X, 32'h2, `RESP_OKAY);
    wr(`REG_DELAY_Y, 32'h1, `RESP_OKAY);
    wr(`REG_MAX_PULSE, 32'h10, `RESP_OKAY);
    wr(`REG_MIN_STANDBY, 32'h14, `RESP_OKAY);
    wr(`REG_DISC1_PULSE, 32'h10, `RESP_OKAY);
    wr(`REG_PLS_DISC_LIM, 32'h20, `RESP_OKAY);
    rd(`REG_MIN_STANDBY, 32'h14, `RESP_OKAY);
    c0 <= 16'h0300;
    c1 <= 16'hFF00;
    pl <= 32'h0400_0400;
    steps(3);
    chk("coil current", 32'hFF00_0300, coil_current);
    chk("plasma current", 32'h0400, {16'h0, plasma_sel});
    chk("fault status", 32'h0, {24'h0, fault_status});
    // a full averaging window of standby samples so the offsets equal the inputs
    steps(100);
    trig(1'b1);
    steps(4);
    chk("pulse state", 32'h0, {31'h0, pulse_state});
    steps(1);
    chk("pulse state", 32'h1, {31'h0, pulse_state});
    chk("prediction", 32'h1, {31'h0, predict_enable});
    steps(2);
    chk("coil current", 32'h0, coil_current);
    chk("plasma current", 32'h0, {16'h0, plasma_sel});
    skew <= 16'h0010;
    steps(3);
    chk("fault status", 32'h0, {24'h0, fault_status});
    skew <= 16'h0011;
    pl <= 32'h0421_0400;
    steps(3);
    chk("fault status", 32'h48, {24'h0, fault_status});
    chk("fault", 32'h1, {31'h0, fault});
    skew <= 16'h0000;
    pl <= 32'h0400_0400;
    steps(1);
    chk("fault status", 32'h48, {24'h0, fault_status});
    wr(`REG_CTRL, 32'h1, `RESP_OKAY);
    chk("fault status", 32'h0, {24'h0, fault_status});
    steps(8);
    chk("fault status", 32'h1, {24'h0, fault_status});
    trig(1'b0);
    steps(3);
    chk("pulse state", 32'h1, {31'h0, pulse_state});
    steps(1);
    chk("pulse state", 32'h0, {31'h0, pulse_state});
    wr(`REG_CTRL, 32'h1, `RESP_OKAY);
    trig(1'b1);
    steps(5);
    chk("fault status", 32'h2, {24'h0, fault_status});
    trig(1'b0);
    steps(3);
    wr(`REG_PLS_STBY_LIM, 32'h300, `RESP_OKAY);
    wr(`REG_COIL_OFS_LIM, 32'h100, `RESP_OKAY);
    wr(`REG_PLS_OFS_LIM, 32'h100, `RESP_OKAY);
    wr(`REG_CTRL, 32'h1, `RESP_OKAY);
    steps(2);
    chk("fault status", 32'hA4, {24'h0, fault_status});
    rd(`REG_STATUS, 32'hA400, `RESP_OKAY);
    rd(`REG_COIL_BASE, 32'h0300, `RESP_OKAY);
    rd(8'h44, 32'hFF00, `RESP_OKAY);
    wr(`REG_CTRL, 32'h2, `RESP_OKAY);
    rd(`REG_CTRL, 32'h2, `RESP_OKAY);
    wr(`REG_COEF_CS, 32'h100, `RESP_OKAY);
    steps(2);
    // a settled filter must keep the sign of the negative coil reading
    chk("coil current", 32'hFF00_0300, coil_current);
    chk("plasma current", 32'h0100, {16'h0, plasma_sel});
    end_sim;
  end
endmodule // coil_current_protection_front_end_tb
`default_nettype wire

// ### coil_protect_defs.vh
`ifndef COIL_PROTECT_DEFS_VH
`define COIL_PROTECT_DEFS_VH
// structure
`define NUM_COILS 2
`define SAMPLE_W 16
`define AVG_DEPTH 100
`define AVG_IDX_W 7
// processing time step
`define CLK_HZ 20000000
`define STEP_US 10
`define STEP_CYCLES ((`CLK_HZ / 1000000) * `STEP_US)
`define STEP_CNT_W 12
// filter shift and pick-up coefficient fraction bits
`define FILT_SHIFT 2
`define COEF_FRAC 8
// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_DELAY_X 8'h08
`define REG_DELAY_Y 8'h0C
`define REG_MAX_PULSE 8'h10
`define REG_MIN_STANDBY 8'h14
`define REG_COIL_OFS_LIM 8'h18
`define REG_DISC1_PULSE 8'h1C
`define REG_DISC1_STBY 8'h20
`define REG_DISC2_PULSE 8'h24
`define REG_DISC2_STBY 8'h28
`define REG_PLS_OFS_LIM 8'h2C
`define REG_PLS_DISC_LIM 8'h30
`define REG_PLS_STBY_LIM 8'h34
`define REG_COEF_CS 8'h38
`define REG_COEF_PF 8'h3C
`define REG_COIL_BASE 8'h40
`define REG_PLASMA 8'h48
// control fields
`define CTRL_FAULT_CLR 0
`define CTRL_FILT_EN 1
// fault bit positions
`define FLT_PULSE_LONG 0
`define FLT_STBY_SHORT 1
`define FLT_COIL_OFS 2
`define FLT_DISC1 3
`define FLT_DISC2 4
`define FLT_PLS_OFS 5
`define FLT_PLS_DISC 6
`define FLT_PLS_STBY 7
`define NUM_FAULTS 8
// reset values
`define RST_ZERO 16'h0000
`define RST_LIMIT 16'h7FFF
`define RST_MAX_PULSE 16'hFFFF
// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### coil_protect_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "coil_protect_defs.vh"
module coil_protect_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [`NUM_COILS*`SAMPLE_W-1:0] coil_current,
  input wire logic pulse_state,
  input wire logic predict_enable,
  input wire logic step_done,
  input wire logic fault,
  input wire logic [`NUM_FAULTS-1:0] fault_status
);
  logic [7:0] gap_q;
  logic seen_q;
  logic [2:0] clr_age_q;
  wire logic wr_clr = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid &&
    s_axi_awaddr[7:0] == `REG_CTRL && s_axi_wstrb[0] && s_axi_wdata[0];
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // counters saturate so a stalled step or an old clear is never hidden by wrap-around
  always @(posedge aclk) begin
    if (!aresetn) begin
      gap_q <= 8'h00;
      seen_q <= 1'b0;
      clr_age_q <= 3'h7;
    end else begin
      gap_q <= step_done ? 8'h00 : gap_q + {7'h0, gap_q != 8'hFF};
      seen_q <= seen_q | step_done;
      clr_age_q <= wr_clr ? 3'h0 : clr_age_q + {2'h0, clr_age_q != 3'h7};
    end
  end
  sequence wr_take;
    s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  endsequence
  sequence rd_take;
    s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  endsequence
  a_fault_summary: assert property (fault == |fault_status)
    else $error("fault summary differs from status bits");
  a_predict_pulse: assert property (predict_enable == pulse_state)
    else $error("prediction enable differs from pulse state");
  a_step_period: assert property (step_done && seen_q |-> gap_q == 8'hC7)
    else $error("step strobe spacing is not 200 cycles");
  a_state_at_tick: assert property ($changed(pulse_state) |-> gap_q < 8'h03 || gap_q > 8'hC4)
    else $error("pulse state moved away from a step boundary");
  a_output_at_tick: assert property ($changed(coil_current) |-> gap_q < 8'h03 || gap_q > 8'hC4)
    else $error("coil current moved away from a step boundary");
  a_fault_sticky: assert property (|($past(fault_status) & ~fault_status) |-> clr_age_q < 3'h3)
    else $error("fault bit dropped without a clear command");
  a_write_answer: assert property (wr_take |=> s_axi_awready && s_axi_wready && !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write handshake or response not in the expected cycle");
  a_read_answer: assert property (rd_take |=> s_axi_arready && !s_axi_rvalid ##1 s_axi_rvalid)
    else $error("read handshake or data not in the expected cycle");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held until accepted");
  a_unmapped_read: assert property (rd_take ##0 s_axi_araddr > 32'h0000007F |=>
    s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule // coil_protect_sva
bind coil_current_protection_front_end coil_protect_sva chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .coil_current(coil_current), .pulse_state(pulse_state), .predict_enable(predict_enable),
  .step_done(step_done), .fault(fault), .fault_status(fault_status));
`default_nettype wire

// ### sensor_front.sv
`timescale 1ns/1ps
`default_nettype none
module sensor_front (
  input wire logic aclk,
  input wire logic sop_req,
  input wire logic eop_req,
  input wire logic [15:0] c0,
  input wire logic [15:0] c1,
  input wire logic [15:0] skew,
  input wire logic [31:0] pl,
  output logic sop,
  output logic eop,
  output logic [63:0] direct,
  output logic [63:0] cond,
  output logic [31:0] plasma
);
  logic [3:0] sop_cnt_q = 4'h0;
  logic [3:0] eop_cnt_q = 4'h0;
  // triggers are stretched so the receiving synchroniser cannot miss a one-cycle request
  always @(posedge aclk) begin
    sop_cnt_q <= sop_req ? 4'hF : sop_cnt_q - {3'h0, sop_cnt_q != 4'h0};
    eop_cnt_q <= eop_req ? 4'hF : eop_cnt_q - {3'h0, eop_cnt_q != 4'h0};
  end
  assign sop = sop_cnt_q != 4'h0;
  assign eop = eop_cnt_q != 4'h0;
  // both transducers of a coil read alike; skew disturbs only the conditioned copy of coil0 a
  assign direct = {c1, c1, c0, c0};
  assign cond = {c1, c1, c0, c0 + skew};
  assign plasma = pl;
endmodule // sensor_front
`default_nettype wire
